/* hw/gdppg_pkg.sv */
package gdppg_pkg;

	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [7:0] GDPPG_OFS_RUN      = 8'h00;
	localparam logic [7:0] GDPPG_OFS_CTRL     = 8'h04;
	localparam logic [7:0] GDPPG_OFS_RESTART  = 8'h08;
	localparam logic [7:0] GDPPG_OFS_STATUS   = 8'h0C;
	localparam logic [7:0] GDPPG_OFS_INCTRL   = 8'h10;
	localparam logic [7:0] GDPPG_OFS_OUTCTRL  = 8'h14;
	localparam logic [7:0] GDPPG_OFS_CMP_A    = 8'h18;
	localparam logic [7:0] GDPPG_OFS_CMP_B    = 8'h1C;
	localparam logic [7:0] GDPPG_OFS_CMP_C    = 8'h20;
	localparam logic [7:0] GDPPG_OFS_CMP_D    = 8'h24;
	localparam logic [7:0] GDPPG_OFS_CYCLE    = 8'h28;
	localparam logic [7:0] GDPPG_OFS_TRG      = 8'h2C;
	localparam logic [7:0] GDPPG_OFS_CAP_RISE = 8'h30;
	localparam logic [7:0] GDPPG_OFS_CAP_FALL = 8'h34;
	localparam logic [7:0] GDPPG_OFS_EMG_CTRL = 8'h38;
	localparam logic [7:0] GDPPG_OFS_EMG_STAT = 8'h3C;
	localparam logic [7:0] GDPPG_OFS_COUNTER  = 8'h40;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int GDPPG_RUN_COUNTER_BIT  = 0;
	localparam int GDPPG_RUN_PRESC_BIT    = 1;
	localparam int GDPPG_RESTART_BIT      = 0;
	localparam int GDPPG_EDGE_SEL_BIT     = 6;
	localparam int GDPPG_EMG_EN_BIT       = 0;
	localparam int GDPPG_EMG_OC_BIT       = 1;
	localparam int GDPPG_EMG_RET_BIT      = 2;
	localparam int GDPPG_EMG_FLT_LSB      = 4;
	localparam int GDPPG_EMG_STAT_ACT_BIT = 0;
	localparam int GDPPG_EMG_STAT_IN_BIT  = 1;
	localparam int GDPPG_OUT_EN_LSB       = 0;
	localparam int GDPPG_OUT_POL_LSB      = 4;

	// ----------------------------------------
	// Reset values and timing
	// ----------------------------------------
	localparam logic [15:0] GDPPG_CMP_RESET   = 16'h0000;
	localparam logic [3:0]  GDPPG_PRESC_RESET = 4'h0;
	localparam int          GDPPG_FLT_STEP    = 16;
	localparam logic [1:0]  GDPPG_TAP_BASE    = 2'h0;

	typedef enum logic [1:0] {
		GDPPG_MODE_CMD_CAP = 2'b00,
		GDPPG_MODE_CMD_TRG = 2'b01,
		GDPPG_MODE_TRG     = 2'b10,
		GDPPG_MODE_RSVD    = 2'b11
	} gdppg_mode_t;

	typedef struct packed {
		logic        start_irq_disable;
		logic [1:0]  cycle_irq_divider;
		gdppg_mode_t start_mode;
		logic [1:0]  source_clock_sel;
	} gdppg_ctrl_t;

	typedef struct packed {
		logic [15:0] cmp_a;
		logic [15:0] cmp_b;
		logic [15:0] cmp_c;
		logic [15:0] cmp_d;
		logic [15:0] cycle;
		logic [15:0] trg;
	} gdppg_cmp_t;

endpackage

/* hw/gdppg_timer.sv */
// Decided for this implementation: the APB register port and the register addresses.
`timescale 1ns/1ps
// Behaviour
// - In protection outputs go inactive when state select is 0, released when 1.
// - Protection circuit works only while its enable bit is 1.
// - Status shows filtered fault input level in bit 1, protection active in bit 0.
// - Trigger output pulses when counter equals trigger compare value.
// - Prescaler counts while its run bit is 1, else stops and clears.
// - Counter is 16 bits, clocked from prescaler tap divide 1, 2, 4 or 8.
// - Run bit 1 starts counting, or in GDPPG_MODE_TRG arms it for the start edge; 0 stops and clears the counter.
// - Writing restart bit clears counter and counts on from zero.
// - Counter clears when it equals the cycle value.
// - In trigger start modes the stop level stops and clears the counter.
// - Base tap gives period M+1, slower taps give period M.
// - Cycle buffer moves to active cycle at the next cycle match clear.
// - Compare and trigger buffers load at the cycle match clear.
// - Stopped writes go direct, running writes go to buffers, reads show active.
// - In command capture mode rising edge captures to first, falling to second.
// - Each capture raises its own capture interrupt pulse.
// - Outputs idle at polarity, drive only when enabled, both off after reset.
// - Trigger start interrupt on start edge in trigger modes, and during protection.
// - Outside GDPPG_MODE_TRG, cycle interrupt at command start and every one, two or four matches.
// - Start interrupt can be disabled; stop level at run waits for start edge.
// - Second output goes active when counter equals third compare value.
// - Second output goes inactive when counter equals fourth compare value.
module gdppg_timer
	import gdppg_pkg::*;
#(
	parameter int CNT_W = 16
) (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	// Pins
	input  wire logic        trigger_input_pin,
	input  wire logic        emergency_fault_input,
	output logic             ppg_output_a,
	output logic             ppg_output_a_oe,
	output logic             ppg_output_b,
	output logic             ppg_output_b_oe,
	output logic             trigger_out,
	// Event pulses
	output logic             capture_rise_irq,
	output logic             capture_fall_irq,
	output logic             trigger_start_irq,
	output logic             cycle_irq
);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic tap_tick(input logic [1:0] sel, input logic [3:0] p, input logic en);
		logic r;
		r = en;
		unique case (sel)
			2'h0: r = en;
			2'h1: r = en & p[0];
			2'h2: r = en & (&p[1:0]);
			2'h3: r = en & (&p[2:0]);
		endcase
		return r;
	endfunction

	function automatic logic [31:0] zx16(input logic [CNT_W-1:0] v);
		return {16'h0000, v};
	endfunction

	// ----------------------------------------
	// State
	// ----------------------------------------
	logic              counter_run_reg;
	logic              prescaler_run_reg;
	gdppg_ctrl_t       ctrl_reg;
	logic              trigger_edge_sel_reg;
	logic [1:0]        output_enable_reg;
	logic [1:0]        output_idle_polarity_reg;
	gdppg_cmp_t        act_reg;
	gdppg_cmp_t        buf_reg;
	logic [5:0]        buf_pend_reg;
	logic [CNT_W-1:0]  capture_rise_reg;
	logic [CNT_W-1:0]  capture_fall_reg;
	logic              fault_protect_enable_reg;
	logic              fault_output_state_sel_reg;
	logic [3:0]        fault_filter_sel_reg;
	logic [3:0]        presc_reg;
	logic [CNT_W-1:0]  up_counter_reg;
	logic [CNT_W-1:0]  cnt_next;
	logic              counting_reg;
	logic              trig_prev_reg;
	logic              fault_input_level_reg;
	logic [7:0]        fault_flt_cnt_reg;
	logic              fault_protect_active_reg;
	logic [1:0]        cyc_div_reg;
	logic              out_a_lvl_reg;
	logic              out_b_lvl_reg;

	// ----------------------------------------
	// APB decode
	// ----------------------------------------
	logic wr_en;
	logic rd_setup;
	logic run_wr;
	logic restart_wr;
	logic fault_ret_wr;
	logic known_addr;

	assign wr_en        = psel & penable & pwrite & pready;
	assign rd_setup     = psel & ~penable;
	assign run_wr       = wr_en & (paddr == GDPPG_OFS_RUN);
	assign restart_wr   = wr_en & (paddr == GDPPG_OFS_RESTART) & pwdata[GDPPG_RESTART_BIT];
	assign fault_ret_wr = wr_en & (paddr == GDPPG_OFS_EMG_CTRL) & pwdata[GDPPG_EMG_RET_BIT];

	always_comb begin
		unique case (paddr)
			GDPPG_OFS_RUN, GDPPG_OFS_CTRL, GDPPG_OFS_RESTART, GDPPG_OFS_STATUS,
			GDPPG_OFS_INCTRL, GDPPG_OFS_OUTCTRL, GDPPG_OFS_CMP_A, GDPPG_OFS_CMP_B,
			GDPPG_OFS_CMP_C, GDPPG_OFS_CMP_D, GDPPG_OFS_CYCLE, GDPPG_OFS_TRG,
			GDPPG_OFS_CAP_RISE, GDPPG_OFS_CAP_FALL, GDPPG_OFS_EMG_CTRL,
			GDPPG_OFS_EMG_STAT, GDPPG_OFS_COUNTER: known_addr = 1'b1;
			default: known_addr = 1'b0;
		endcase
	end

	// ----------------------------------------
	// APB answer, no wait state
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
		end else begin
			pready  <= rd_setup;
			pslverr <= rd_setup & ~known_addr;
			if (rd_setup & ~pwrite) begin
				unique case (paddr)
					GDPPG_OFS_RUN:      prdata <= {30'h0, prescaler_run_reg, counter_run_reg};
					GDPPG_OFS_CTRL:     prdata <= {25'h0, ctrl_reg};
					GDPPG_OFS_STATUS:   prdata <= {31'h0, counting_reg};
					GDPPG_OFS_INCTRL:   prdata <= {25'h0, trigger_edge_sel_reg, 6'h00};
					GDPPG_OFS_OUTCTRL:  prdata <= {26'h0, output_idle_polarity_reg, 2'h0,
						output_enable_reg};
					GDPPG_OFS_CMP_A:    prdata <= zx16(act_reg.cmp_a);
					GDPPG_OFS_CMP_B:    prdata <= zx16(act_reg.cmp_b);
					GDPPG_OFS_CMP_C:    prdata <= zx16(act_reg.cmp_c);
					GDPPG_OFS_CMP_D:    prdata <= zx16(act_reg.cmp_d);
					GDPPG_OFS_CYCLE:    prdata <= zx16(act_reg.cycle);
					GDPPG_OFS_TRG:      prdata <= zx16(act_reg.trg);
					GDPPG_OFS_CAP_RISE: prdata <= zx16(capture_rise_reg);
					GDPPG_OFS_CAP_FALL: prdata <= zx16(capture_fall_reg);
					GDPPG_OFS_EMG_CTRL: prdata <= {24'h0, fault_filter_sel_reg, 2'h0,
						fault_output_state_sel_reg, fault_protect_enable_reg};
					GDPPG_OFS_EMG_STAT: prdata <= {30'h0, fault_input_level_reg,
						fault_protect_active_reg};
					GDPPG_OFS_COUNTER:  prdata <= zx16(up_counter_reg);
					default:            prdata <= 32'h00000000;
				endcase
			end
		end
	end

	// ----------------------------------------
	// Control registers
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			counter_run_reg            <= 1'b0;
			prescaler_run_reg          <= 1'b0;
			ctrl_reg                   <= '0;
			trigger_edge_sel_reg       <= 1'b0;
			output_enable_reg          <= 2'h0;
			output_idle_polarity_reg   <= 2'h0;
			fault_protect_enable_reg   <= 1'b0;
			fault_output_state_sel_reg <= 1'b0;
			fault_filter_sel_reg       <= 4'h0;
		end else if (wr_en) begin
			unique case (paddr)
				GDPPG_OFS_RUN: begin
					counter_run_reg   <= pwdata[GDPPG_RUN_COUNTER_BIT];
					prescaler_run_reg <= pwdata[GDPPG_RUN_PRESC_BIT];
				end
				GDPPG_OFS_CTRL:    ctrl_reg <= gdppg_ctrl_t'(pwdata[6:0]);
				GDPPG_OFS_INCTRL:  trigger_edge_sel_reg <= pwdata[GDPPG_EDGE_SEL_BIT];
				GDPPG_OFS_OUTCTRL: begin
					output_enable_reg        <= pwdata[GDPPG_OUT_EN_LSB +: 2];
					output_idle_polarity_reg <= pwdata[GDPPG_OUT_POL_LSB +: 2];
				end
				GDPPG_OFS_EMG_CTRL: begin
					fault_protect_enable_reg   <= pwdata[GDPPG_EMG_EN_BIT];
					fault_output_state_sel_reg <= pwdata[GDPPG_EMG_OC_BIT];
					fault_filter_sel_reg       <= pwdata[GDPPG_EMG_FLT_LSB +: 4];
				end
				default: ;
			endcase
		end
	end

	// ----------------------------------------
	// Prescaler and taps
	// ----------------------------------------
	logic tick;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			presc_reg <= GDPPG_PRESC_RESET;
		end else if (prescaler_run_reg) begin
			presc_reg <= presc_reg + 4'h1;
		end else begin
			presc_reg <= GDPPG_PRESC_RESET;
		end
	end

	assign tick = tap_tick(ctrl_reg.source_clock_sel, presc_reg, prescaler_run_reg);

	// ----------------------------------------
	// Trigger input and start control
	// ----------------------------------------
	logic trig_active;
	logic start_edge;
	logic stop_level;
	logic rise_edge;
	logic fall_edge;
	logic trig_mode;
	logic run_start;
	logic cmd_start;
	logic begin_count;
	logic end_count;

	assign trig_active = trigger_input_pin ^ trigger_edge_sel_reg;
	assign rise_edge   = trigger_input_pin & ~trig_prev_reg;
	assign fall_edge   = ~trigger_input_pin & trig_prev_reg;
	assign start_edge  = trigger_edge_sel_reg ? fall_edge : rise_edge;
	assign stop_level  = ~trig_active;
	assign trig_mode   = (ctrl_reg.start_mode == GDPPG_MODE_CMD_TRG) |
		(ctrl_reg.start_mode == GDPPG_MODE_TRG);
	assign run_start   = run_wr & pwdata[GDPPG_RUN_COUNTER_BIT] & ~counter_run_reg;
	assign cmd_start   = run_start & (ctrl_reg.start_mode != GDPPG_MODE_TRG) &
		~((ctrl_reg.start_mode == GDPPG_MODE_CMD_TRG) & stop_level);
	assign begin_count = cmd_start | (trig_mode & counter_run_reg & start_edge & ~counting_reg);
	assign end_count   = (run_wr & ~pwdata[GDPPG_RUN_COUNTER_BIT]) |
		(trig_mode & counting_reg & stop_level);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			trig_prev_reg <= 1'b0;
			counting_reg  <= 1'b0;
		end else begin
			trig_prev_reg <= trigger_input_pin;
			if (end_count) begin
				counting_reg <= 1'b0;
			end else if (begin_count) begin
				counting_reg <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// Up-counter
	// ----------------------------------------
	logic cyc_hit;
	logic slow_tap;
	logic advance;

	assign slow_tap = ctrl_reg.source_clock_sel != GDPPG_TAP_BASE;
	assign cyc_hit  = counting_reg & (up_counter_reg == act_reg.cycle) &
		(slow_tap | tick);

	always_comb begin
		cnt_next = up_counter_reg;
		advance  = 1'b0;
		if (end_count | restart_wr | begin_count) begin
			cnt_next = '0;
			advance  = begin_count | restart_wr;
		end else if (cyc_hit) begin
			cnt_next = '0;
			advance  = 1'b1;
		end else if (counting_reg & tick) begin
			cnt_next = up_counter_reg + 16'h0001;
			advance  = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			up_counter_reg <= '0;
		end else begin
			up_counter_reg <= cnt_next;
		end
	end

	// ----------------------------------------
	// Compare registers with buffers
	// ----------------------------------------
	logic [5:0] cmp_sel;

	always_comb begin
		cmp_sel = 6'h00;
		if (wr_en) begin
			unique case (paddr)
				GDPPG_OFS_CMP_A: cmp_sel = 6'h20;
				GDPPG_OFS_CMP_B: cmp_sel = 6'h10;
				GDPPG_OFS_CMP_C: cmp_sel = 6'h08;
				GDPPG_OFS_CMP_D: cmp_sel = 6'h04;
				GDPPG_OFS_CYCLE: cmp_sel = 6'h02;
				GDPPG_OFS_TRG:   cmp_sel = 6'h01;
				default:         cmp_sel = 6'h00;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			act_reg      <= {6{GDPPG_CMP_RESET}};
			buf_reg      <= {6{GDPPG_CMP_RESET}};
			buf_pend_reg <= 6'h00;
		end else begin
			for (int i = 0; i < 6; i++) begin
				if (cmp_sel[i] & ~counter_run_reg) begin
					act_reg[i*16 +: 16] <= pwdata[15:0];
				end else if (cmp_sel[i]) begin
					buf_reg[i*16 +: 16] <= pwdata[15:0];
					buf_pend_reg[i]     <= 1'b1;
				end else if (cyc_hit & buf_pend_reg[i]) begin
					act_reg[i*16 +: 16] <= buf_reg[i*16 +: 16];
					buf_pend_reg[i]     <= 1'b0;
				end
			end
		end
	end

	// ----------------------------------------
	// Capture and events
	// ----------------------------------------
	logic cap_mode;
	logic cyc_irq_due;
	logic start_irq_ev;

	assign cap_mode     = (ctrl_reg.start_mode == GDPPG_MODE_CMD_CAP) & counting_reg;
	assign start_irq_ev = trig_mode & ((begin_count & ~cmd_start) |
		(fault_protect_active_reg & start_edge));
	assign cyc_irq_due  = (ctrl_reg.cycle_irq_divider == 2'h0) |
		((ctrl_reg.cycle_irq_divider == 2'h1) & cyc_div_reg[0]) |
		(cyc_div_reg == 2'h3);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			capture_rise_reg  <= '0;
			capture_fall_reg  <= '0;
			capture_rise_irq  <= 1'b0;
			capture_fall_irq  <= 1'b0;
			trigger_start_irq <= 1'b0;
			cycle_irq         <= 1'b0;
			trigger_out       <= 1'b0;
			cyc_div_reg       <= 2'h0;
		end else begin
			if (cap_mode & rise_edge) begin
				capture_rise_reg <= up_counter_reg;
			end
			if (cap_mode & fall_edge) begin
				capture_fall_reg <= up_counter_reg;
			end
			capture_rise_irq  <= cap_mode & rise_edge;
			capture_fall_irq  <= cap_mode & fall_edge;
			trigger_start_irq <= start_irq_ev;
			trigger_out       <= counting_reg & advance & (cnt_next == act_reg.trg);
			if (begin_count) begin
				cyc_div_reg <= 2'h0;
			end else if (cyc_hit) begin
				cyc_div_reg <= cyc_div_reg + 2'h1;
			end
			cycle_irq <= (ctrl_reg.start_mode != GDPPG_MODE_TRG) &
				((cmd_start & ~ctrl_reg.start_irq_disable) |
				(cyc_hit & cyc_irq_due));
		end
	end

	// ----------------------------------------
	// Emergency protection
	// ----------------------------------------
	logic [7:0] flt_limit;

	assign flt_limit = 8'(fault_filter_sel_reg * GDPPG_FLT_STEP);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fault_input_level_reg    <= 1'b0;
			fault_flt_cnt_reg        <= 8'h00;
			fault_protect_active_reg <= 1'b0;
		end else begin
			if (emergency_fault_input == fault_input_level_reg) begin
				fault_flt_cnt_reg <= 8'h00;
			end else if (fault_flt_cnt_reg >= flt_limit) begin
				fault_input_level_reg <= emergency_fault_input;
				fault_flt_cnt_reg     <= 8'h00;
			end else begin
				fault_flt_cnt_reg <= fault_flt_cnt_reg + 8'h01;
			end
			if (fault_protect_enable_reg & ~fault_input_level_reg) begin
				fault_protect_active_reg <= 1'b1;
			end else if (fault_ret_wr | ~fault_protect_enable_reg) begin
				fault_protect_active_reg <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// PPG outputs
	// ----------------------------------------
	logic a_next;
	logic b_next;

	always_comb begin
		a_next = out_a_lvl_reg;
		b_next = out_b_lvl_reg;
		if (!counting_reg || begin_count) begin
			a_next = output_idle_polarity_reg[0];
			b_next = output_idle_polarity_reg[1];
		end else if (advance) begin
			if (cnt_next == act_reg.cmp_a) begin
				a_next = ~output_idle_polarity_reg[0];
			end else if (cnt_next == act_reg.cmp_b) begin
				a_next = output_idle_polarity_reg[0];
			end
			if (cnt_next == act_reg.cmp_c) begin
				b_next = ~output_idle_polarity_reg[1];
			end else if (cnt_next == act_reg.cmp_d) begin
				b_next = output_idle_polarity_reg[1];
			end
		end
		if (fault_protect_active_reg) begin
			a_next = output_idle_polarity_reg[0];
			b_next = output_idle_polarity_reg[1];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			out_a_lvl_reg   <= 1'b0;
			out_b_lvl_reg   <= 1'b0;
			ppg_output_a    <= 1'b0;
			ppg_output_b    <= 1'b0;
			ppg_output_a_oe <= 1'b0;
			ppg_output_b_oe <= 1'b0;
		end else begin
			out_a_lvl_reg   <= a_next;
			out_b_lvl_reg   <= b_next;
			ppg_output_a    <= a_next;
			ppg_output_b    <= b_next;
			ppg_output_a_oe <= output_enable_reg[0] &
				~(fault_protect_active_reg & fault_output_state_sel_reg);
			ppg_output_b_oe <= output_enable_reg[1] &
				~(fault_protect_active_reg & fault_output_state_sel_reg);
		end
	end

endmodule

/* dv/gdppg_monitor.sv */
`timescale 1ns/1ps
module gdppg_monitor (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Bus
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	// Events and pins
	input wire logic trigger_out,
	input wire logic cycle_irq,
	input wire logic capture_rise_irq,
	input wire logic capture_fall_irq,
	input wire logic ppg_output_a_oe,
	input wire logic ppg_output_b_oe
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_rdy; psel && !penable |=> pready; endproperty
	a_rdy: assert property (p_rdy) else $error("no ready after setup");
	property p_acc; pready |-> psel && penable; endproperty
	a_acc: assert property (p_acc) else $error("ready outside access");
	property p_err; pslverr |-> pready; endproperty
	a_err: assert property (p_err) else $error("error without ready");
	property p_trg; trigger_out |=> !trigger_out; endproperty
	a_trg: assert property (p_trg) else $error("trigger pulse too long");
	property p_cyc; cycle_irq |=> !cycle_irq; endproperty
	a_cyc: assert property (p_cyc) else $error("cycle pulse too long");
	property p_cap; capture_rise_irq |-> !capture_fall_irq ##1 !capture_rise_irq; endproperty
	a_cap: assert property (p_cap) else $error("capture pulses clash");
	property p_capf; capture_fall_irq |=> !capture_fall_irq; endproperty
	a_capf: assert property (p_capf) else $error("fall pulse too long");
	property p_oe; $rose(presetn) |-> !ppg_output_a_oe && !ppg_output_b_oe; endproperty
	a_oe: assert property (p_oe) else $error("output driven after reset");
	c_cyc: cover property (cycle_irq);
	c_rise: cover property (capture_rise_irq);
	c_err: cover property (pslverr);
endmodule

/* dv/gdppg_partner.sv */
`timescale 1ns/1ps
module gdppg_partner (
	// Clock and bench requests
	input wire logic pclk,
	input wire logic trig_req,
	input wire logic flt_req,
	// Gate driver side
	input wire logic out_b,
	input wire logic oe_b,
	output logic     pin_trg,
	output logic     pin_flt,
	output logic     pad_b
);
	initial begin
		pin_trg = 1'b0;
		pin_flt = 1'b1;
	end
	always @(posedge pclk) begin
		pin_trg <= trig_req;
		pin_flt <= flt_req;
	end
	// Gate input has a pull-down
	assign pad_b = oe_b ? out_b : 1'b0;
endmodule

/* dv/gdppg_timer_tb.sv */
`timescale 1ns/1ps
module gdppg_timer_tb;
	import gdppg_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, trig_req, flt_req, err;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd, v;
	logic        pready, pslverr, pin_trg, pin_flt, out_a, oe_a, out_b, oe_b, pad_b;
	logic [4:0]  ev;
	int          n, n_fail, checks_done;

	gdppg_timer gdppg_timer_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .trigger_input_pin(pin_trg), .emergency_fault_input(pin_flt),
		.ppg_output_a(out_a), .ppg_output_a_oe(oe_a), .ppg_output_b(out_b),
		.ppg_output_b_oe(oe_b), .trigger_out(ev[1]), .capture_rise_irq(ev[2]),
		.capture_fall_irq(ev[3]), .trigger_start_irq(ev[4]), .cycle_irq(ev[0]));
	gdppg_partner gdppg_partner_i (.pclk(pclk), .trig_req(trig_req), .flt_req(flt_req),
		.out_b(out_b), .oe_b(oe_b), .pin_trg(pin_trg), .pin_flt(pin_flt), .pad_b(pad_b));

	task close_out;
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task chk(input string s, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", s, e, g);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
		chk("pready", 1, pready);
		if (n == 50) close_out;
		rd = prdata; err = pslverr;
		psel <= 1'b0; penable <= 1'b0;
		@(posedge pclk);
	endtask
	task rd_chk(input string s, input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 0);
		chk(s, e, rd);
	endtask
	task wt(input int k);
		n = 0;
		do begin @(posedge pclk); n++; end while (ev[k] !== 1'b1 && n < 300);
		chk("event", 1, ev[k]);
		if (n == 300) close_out;
	endtask

	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	initial begin
		presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
		trig_req = 0; flt_req = 1; n_fail = 0; checks_done = 0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk("oe reset", 0, {oe_a, oe_b});
		apb(1'b0, 8'hFC, 0);
		chk("unmapped rd", 0, rd);
		chk("unmapped err", 1, err);
		rd_chk("trg reset", GDPPG_OFS_TRG, 0);
		rd_chk("emg idle", GDPPG_OFS_EMG_STAT, 32'h2);
		apb(1'b1, GDPPG_OFS_CYCLE, 4);
		apb(1'b1, GDPPG_OFS_TRG, 2);
		apb(1'b1, GDPPG_OFS_CMP_C, 1);
		apb(1'b1, GDPPG_OFS_CMP_D, 3);
		apb(1'b1, GDPPG_OFS_OUTCTRL, 32'h3);
		rd_chk("cyc direct", GDPPG_OFS_CYCLE, 4);
		apb(1'b1, GDPPG_OFS_CTRL, 0);
		apb(1'b1, GDPPG_OFS_RUN, 32'h3);
		repeat (3) wt(0);
		chk("cyc period", 5, n);
		repeat (2) wt(1);
		chk("trg period", 5, n);
		apb(1'b1, GDPPG_OFS_CYCLE, 6);
		rd_chk("cyc buffered", GDPPG_OFS_CYCLE, 4);
		repeat (3) wt(0);
		chk("cyc new period", 7, n);
		rd_chk("cyc active", GDPPG_OFS_CYCLE, 6);
		trig_req <= 1'b1;
		wt(2);
		rd_chk("cap rise", GDPPG_OFS_CAP_RISE, 5);
		chk("cap range", 1, rd <= 6);
		trig_req <= 1'b0;
		wt(3);
		rd_chk("cap fall", GDPPG_OFS_CAP_FALL, 4);
		apb(1'b1, GDPPG_OFS_RUN, 32'h1);
		apb(1'b0, GDPPG_OFS_COUNTER, 0);
		v = rd;
		rd_chk("frozen", GDPPG_OFS_COUNTER, v);
		apb(1'b1, GDPPG_OFS_RESTART, 32'h1);
		rd_chk("restart", GDPPG_OFS_COUNTER, 0);
		apb(1'b1, GDPPG_OFS_RUN, 0);
		rd_chk("stopped", GDPPG_OFS_STATUS, 0);
		apb(1'b1, GDPPG_OFS_EMG_CTRL, 32'h1);
		flt_req <= 1'b0;
		repeat (5) @(posedge pclk);
		rd_chk("emg active", GDPPG_OFS_EMG_STAT, 32'h1);
		chk("inactive", 32'h2, {oe_b, pad_b});
		apb(1'b1, GDPPG_OFS_EMG_CTRL, 32'h3);
		@(posedge pclk);
		chk("hi z", 0, {oe_a, oe_b});
		flt_req <= 1'b1;
		repeat (5) @(posedge pclk);
		apb(1'b1, GDPPG_OFS_EMG_CTRL, 32'h5);
		rd_chk("emg return", GDPPG_OFS_EMG_STAT, 32'h2);
		apb(1'b1, GDPPG_OFS_EMG_CTRL, 0);
		flt_req <= 1'b0;
		repeat (5) @(posedge pclk);
		rd_chk("emg off", GDPPG_OFS_EMG_STAT, 0);
		apb(1'b1, GDPPG_OFS_CTRL, 32'h9);
		apb(1'b1, GDPPG_OFS_RUN, 32'h3);
		trig_req <= 1'b1;
		wt(4);
		wt(1);
		wt(1);
		chk("slow period", 12, n);
		chk("b active", 1, pad_b);
		chk("a drive", 32'h3, {out_a, oe_a});
		repeat (2) @(posedge pclk);
		chk("b idle", 0, pad_b);
		trig_req <= 1'b0;
		repeat (2) @(posedge pclk);
		rd_chk("stop level", GDPPG_OFS_STATUS, 0);
		rd_chk("stop clear", GDPPG_OFS_COUNTER, 0);
		close_out;
	end
endmodule

bind gdppg_timer gdppg_monitor gdppg_monitor_i (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pready(pready), .pslverr(pslverr), .trigger_out(trigger_out),
	.cycle_irq(cycle_irq), .capture_rise_irq(capture_rise_irq),
	.capture_fall_irq(capture_fall_irq), .ppg_output_a_oe(ppg_output_a_oe),
	.ppg_output_b_oe(ppg_output_b_oe));
